/* File: include/fpm_consts.vh */
// constants for the float multiplier and accumulator-clear datapath
// Notes on behaviour
// - accumulator clear zeroes all 80 bits of the chosen accumulator
// - clear exists only for foreground or background accumulator, not shadow
// - single times single gives a single-precision product in destination
// - single multiply: underflow flag set when unbiased exponent below -126
// - single multiply: overflow flag set when unbiased exponent above 127
// - invalid flag set for any NaN input or infinity times zero
// - negative flag follows the sign of every float product
// - float multiplies set matching stickies; fixed overflow sticky untouched
// - double times double gives a double product in destination pair
// - double times single gives a double product in destination pair
// - single times single gives a double product in destination pair
// - double multiplies use the accumulator picked by the select bit as scratch
// - scratch accumulator holds garbage afterwards; program saves it first
// - every double multiply takes seven cycles in the multiplier
// - low word written after cycle six, high word and status after seven
// - double result: underflow flag set when unbiased exponent below -1022
// - double result: overflow flag set when unbiased exponent above 1023
// - one NaN operand in double multiply: result takes that NaN's sign
// - two NaN operands in double multiply: result sign is OR of signs
`ifndef FPM_CONSTS_VH
`define FPM_CONSTS_VH
// operation codes from the sequencer
`define FPM_OP_NOP 3'h0
`define FPM_OP_CLR 3'h1
`define FPM_OP_SS 3'h2
`define FPM_OP_DD 3'h3
`define FPM_OP_DS 3'h4
`define FPM_OP_SSD 3'h5
// register byte offsets
`define FPM_REG_MODE 4'h0
`define FPM_REG_ARITH 4'h4
`define FPM_REG_STICKY 4'h8
`define FPM_REG_BUSY 4'hc
// field positions
`define FPM_MODE_ACCSEL 0
`define FPM_A_UNDER 0
`define FPM_A_NEG 1
`define FPM_A_INV 2
`define FPM_A_OVER 3
`define FPM_S_FIXOV 0
`define FPM_S_INV 1
`define FPM_S_FPOV 2
`define FPM_S_UNDER 3
// reset values
`define FPM_MODE_RESET 1'b0
`define FPM_FLAGS_RESET 4'h0
// timing in multiplier cycles
`define FPM_DBL_CYCLES 3'h7
`define FPM_LO_CYCLE 3'h6
`define FPM_SCRATCH_CYCLE 3'h3
// exponent limits and biases
`define FPM_SGL_EMIN (-13'sd126)
`define FPM_SGL_EMAX 13'sd127
`define FPM_DBL_EMIN (-13'sd1022)
`define FPM_DBL_EMAX 13'sd1023
`define FPM_SGL_BIAS 13'sd127
`define FPM_DBL_BIAS 13'sd1023
`define FPM_WIDEN_BIAS 11'h380
`define FPM_EXP_PAIR 13'h7fe
`endif

/* File: design/fpm_multiplier.v */
// float multiplier, accumulator clear, status flags and register slave
`include "fpm_consts.vh"
`default_nettype none

module fpm_multiplier #(
  parameter ACC_W = 80
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // operation request from the sequencer
  input wire opValid,
  output wire opReady,
  input wire [2:0] opCode,
  input wire opAccumBg,
  input wire [63:0] opA,
  input wire [63:0] opB,
  // result writes to the register file
  output reg resLoWe,
  output reg resHiWe,
  output reg [31:0] resLo,
  output reg [31:0] resHi,
  // accumulators and status
  output reg [ACC_W-1:0] fgAccum,
  output reg [ACC_W-1:0] bgAccum,
  output reg [3:0] arithStatus,
  output reg [3:0] stickyStatus,
  // axi4-lite slave
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
// helpers

// widen a single to double; denormals flush to zero
// the rebias is exact, so the shared double path sees the true exponent
function [63:0] fpmWiden;
  input [31:0] f;
  begin
    if (f[30:23] == 8'h00) begin
      fpmWiden = {f[31], 63'h0};
    end else if (f[30:23] == 8'hff) begin
      fpmWiden = {f[31], 11'h7ff, f[22:0], 29'h0};
    end else begin
      fpmWiden = {f[31], {3'h0, f[30:23]} + `FPM_WIDEN_BIAS, f[22:0], 29'h0};
    end
  end
endfunction

// true when a register offset is one we decode
function fpmMapped;
  input [3:0] a;
  begin
    fpmMapped = (a == `FPM_REG_MODE) || (a == `FPM_REG_ARITH) ||
      (a == `FPM_REG_STICKY) || (a == `FPM_REG_BUSY);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// state

reg accumSelect;
reg busy;
reg [2:0] cycleCnt;
reg [2:0] heldOp;
reg [63:0] heldA;
reg [63:0] heldB;
reg awHeld;
reg wHeld;
reg [3:0] awAddr;
reg [31:0] wData;
reg [3:0] wStrb;

// new work is refused while a double multiply is in flight
// no queue here: the sequencer holds its request while opReady is low
assign opReady = !busy;
wire accept = opValid && !busy;
// all three double variants share one seven-cycle sequence
wire isDouble = (opCode == `FPM_OP_DD) || (opCode == `FPM_OP_DS) ||
  (opCode == `FPM_OP_SSD);

////////////////////////////////////////////////////////////////////////////////
// operand selection: live inputs when idle, latched while busy
// for op 4 the single arrives in the low word of the second operand

reg [63:0] mulA;
reg [63:0] mulB;
always @* begin
  if (busy) begin
    mulA = heldA;
    mulB = heldB;
  end else begin
    mulA = (opCode == `FPM_OP_DD || opCode == `FPM_OP_DS) ? opA : fpmWiden(opA[31:0]);
    mulB = (opCode == `FPM_OP_DD) ? opB : fpmWiden(opB[31:0]);
  end
end

////////////////////////////////////////////////////////////////////////////////
// one shared double datapath; singles are widened exactly before it

wire signA = mulA[63];
wire signB = mulB[63];
wire [10:0] expA = mulA[62:52];
wire [10:0] expB = mulB[62:52];
wire nanA = (expA == 11'h7ff) && (mulA[51:0] != 52'h0);
wire nanB = (expB == 11'h7ff) && (mulB[51:0] != 52'h0);
wire infA = (expA == 11'h7ff) && (mulA[51:0] == 52'h0);
wire infB = (expB == 11'h7ff) && (mulB[51:0] == 52'h0);
wire zeroA = (expA == 11'h000);
wire zeroB = (expB == 11'h000);
// limitation: rounding is truncation; bits below the mantissa are dropped
wire [105:0] sig = {1'b1, mulA[51:0]} * {1'b1, mulB[51:0]};
wire norm = sig[105];
wire [51:0] mant = norm ? sig[104:53] : sig[103:52];
wire signed [12:0] unbExp = $signed({2'b00, expA} + {2'b00, expB} - `FPM_EXP_PAIR +
  {12'h000, norm});
wire specialInf = infA || infB;
wire specialZero = zeroA || zeroB;
wire finite = !nanA && !nanB && !specialInf && !specialZero;
wire invalid = nanA || nanB || (infA && zeroB) || (zeroA && infB);

// sign of the product, nan cases first
reg prodSign;
always @* begin
  if (nanA && nanB) begin
    prodSign = signA | signB;
  end else if (nanA) begin
    prodSign = signA;
  end else if (nanB) begin
    prodSign = signB;
  end else begin
    prodSign = signA ^ signB;
  end
end

// range checks for both result widths
wire sglUnder = finite && (unbExp < `FPM_SGL_EMIN);
wire sglOver = finite && (unbExp > `FPM_SGL_EMAX);
wire dblUnder = finite && (unbExp < `FPM_DBL_EMIN);
wire dblOver = finite && (unbExp > `FPM_DBL_EMAX);
wire [12:0] sglExpB = unbExp + `FPM_SGL_BIAS;
wire [12:0] dblExpB = unbExp + `FPM_DBL_BIAS;

// single-precision result word; underflow flushes, overflow saturates to infinity
// invalid results are quiet nans with only the top mantissa bit set
reg [31:0] sglResult;
always @* begin
  if (invalid) begin
    sglResult = {prodSign, 8'hff, 1'b1, 22'h0};
  end else if (specialInf || sglOver) begin
    sglResult = {prodSign, 8'hff, 23'h0};
  end else if (specialZero || sglUnder) begin
    sglResult = {prodSign, 31'h0};
  end else begin
    sglResult = {prodSign, sglExpB[7:0], mant[51:29]};
  end
end

// double-precision result pair
reg [63:0] dblResult;
always @* begin
  if (invalid) begin
    dblResult = {prodSign, 11'h7ff, 1'b1, 51'h0};
  end else if (specialInf || dblOver) begin
    dblResult = {prodSign, 11'h7ff, 52'h0};
  end else if (specialZero || dblUnder) begin
    dblResult = {prodSign, 63'h0};
  end else begin
    dblResult = {prodSign, dblExpB[10:0], mant};
  end
end

// arithmetic flag vectors for each width
wire [3:0] sglFlags = {sglOver, invalid, sglResult[31], sglUnder};
wire [3:0] dblFlags = {dblOver, invalid, dblResult[63], dblUnder};

////////////////////////////////////////////////////////////////////////////////
// sequencing, result writes and accumulators

always @(posedge clk or posedge rst) begin
  if (rst) begin
    busy <= 1'b0;
    cycleCnt <= 3'h0;
    heldOp <= `FPM_OP_NOP;
    heldA <= 64'h0;
    heldB <= 64'h0;
    resLoWe <= 1'b0;
    resHiWe <= 1'b0;
    resLo <= 32'h0;
    resHi <= 32'h0;
    fgAccum <= {ACC_W{1'b0}};
    bgAccum <= {ACC_W{1'b0}};
  end else begin
    resLoWe <= 1'b0;
    resHiWe <= 1'b0;
    if (accept && opCode == `FPM_OP_CLR) begin
      // only the two main accumulators can be cleared; no shadow target
      if (opAccumBg) begin
        bgAccum <= {ACC_W{1'b0}};
      end else begin
        fgAccum <= {ACC_W{1'b0}};
      end
    end
    if (accept && opCode == `FPM_OP_SS) begin
      resLo <= sglResult;
      resLoWe <= 1'b1;
    end
    if (accept && isDouble) begin
      busy <= 1'b1;
      cycleCnt <= 3'h1;
      heldOp <= opCode;
      heldA <= mulA;
      heldB <= mulB;
    end
    if (busy) begin
      cycleCnt <= cycleCnt + 3'h1;
      // partial product parked in the scratch accumulator, left there afterwards
      // software must save that accumulator before issuing a double multiply
      if (cycleCnt == `FPM_SCRATCH_CYCLE) begin
        if (accumSelect) begin
          bgAccum <= sig[105:26];
        end else begin
          fgAccum <= sig[105:26];
        end
      end
      if (cycleCnt == `FPM_LO_CYCLE) begin
        resLo <= dblResult[31:0];
        resLoWe <= 1'b1;
      end
      if (cycleCnt == `FPM_DBL_CYCLES) begin
        resHi <= dblResult[63:32];
        resHiWe <= 1'b1;
        busy <= 1'b0;
        cycleCnt <= 3'h0;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// flags; a sticky set in the same cycle as its clear wins

wire dblDone = busy && (cycleCnt == `FPM_DBL_CYCLES);
wire sglDone = accept && (opCode == `FPM_OP_SS);
// software clear rides on the same strobe that completes the register write
wire stickyWrite = awHeld && wHeld && !s_axi_bvalid &&
  (awAddr == `FPM_REG_STICKY) && wStrb[0];
wire [3:0] stickyClear = stickyWrite ? wData[3:0] : 4'h0;
reg [3:0] stickySet;
always @* begin
  stickySet = 4'h0;
  if (sglDone || dblDone) begin
    stickySet[`FPM_S_INV] = sglDone ? sglFlags[`FPM_A_INV] : dblFlags[`FPM_A_INV];
    stickySet[`FPM_S_FPOV] = sglDone ? sglFlags[`FPM_A_OVER] : dblFlags[`FPM_A_OVER];
    stickySet[`FPM_S_UNDER] = sglDone ? sglFlags[`FPM_A_UNDER] : dblFlags[`FPM_A_UNDER];
  end
end

always @(posedge clk or posedge rst) begin
  if (rst) begin
    arithStatus <= `FPM_FLAGS_RESET;
    stickyStatus <= `FPM_FLAGS_RESET;
  end else begin
    if (sglDone) begin
      arithStatus <= sglFlags;
    end else if (dblDone) begin
      arithStatus <= dblFlags;
    end else if (accept && opCode == `FPM_OP_CLR) begin
      // a clear keeps underflow; sign, invalid and overflow drop
      arithStatus[`FPM_A_NEG] <= 1'b0;
      arithStatus[`FPM_A_INV] <= 1'b0;
      arithStatus[`FPM_A_OVER] <= 1'b0;
    end
    // fixed overflow sticky is never set here, only cleared by software
    stickyStatus <= (stickyStatus & ~stickyClear) | stickySet;
  end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave: address and data taken in either order, one write at a time
// trade-off: one outstanding write keeps the slave small at some bus throughput

assign s_axi_awready = !awHeld && !s_axi_bvalid;
assign s_axi_wready = !wHeld && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

always @(posedge clk or posedge rst) begin
  if (rst) begin
    awHeld <= 1'b0;
    wHeld <= 1'b0;
    awAddr <= 4'h0;
    wData <= 32'h0;
    wStrb <= 4'h0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= 2'h0;
    accumSelect <= `FPM_MODE_RESET;
  end else begin
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= {s_axi_awaddr[3:2], 2'h0};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end
    if (awHeld && wHeld && !s_axi_bvalid) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= fpmMapped(awAddr) ? 2'h0 : 2'h3;
      if (awAddr == `FPM_REG_MODE && wStrb[0]) begin
        accumSelect <= wData[`FPM_MODE_ACCSEL];
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
end

// read side answers one cycle after the address is taken
// every aligned word of the four-bit space is mapped, so no error can arise
always @(posedge clk or posedge rst) begin
  if (rst) begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h0;
    s_axi_rresp <= 2'h0;
  end else begin
    if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= fpmMapped({s_axi_araddr[3:2], 2'h0}) ? 2'h0 : 2'h3;
      case ({s_axi_araddr[3:2], 2'h0})
        `FPM_REG_MODE: begin
          s_axi_rdata <= {31'h0, accumSelect};
        end
        `FPM_REG_ARITH: begin
          s_axi_rdata <= {28'h0, arithStatus};
        end
        `FPM_REG_STICKY: begin
          s_axi_rdata <= {28'h0, stickyStatus};
        end
        `FPM_REG_BUSY: begin
          s_axi_rdata <= {31'h0, busy}; // bit0 mirrors a double multiply in flight
        end
        default: begin
          s_axi_rdata <= 32'h0;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
end

endmodule // fpm_multiplier

`default_nettype wire

/* File: verification/fpm_mul_monitor.sv */
// concurrent checks on the float multiplier operation port and status
`default_nettype none
module fpm_mul_monitor #(
  parameter int ACC_W = 80
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // operation port
  input wire logic opValid,
  input wire logic opReady,
  input wire logic [2:0] opCode,
  input wire logic opAccumBg,
  input wire logic resLoWe,
  input wire logic resHiWe,
  input wire logic [31:0] resLo,
  input wire logic [31:0] resHi,
  // state and bus
  input wire logic [ACC_W-1:0] fgAccum,
  input wire logic [ACC_W-1:0] bgAccum,
  input wire logic [3:0] arithStatus,
  input wire logic [3:0] stickyStatus,
  input wire logic s_axi_awready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic take;
  assign take = opValid && opReady;
  ////////////////////////////////////////////////////////////////////////////////
  // double request accepted
  sequence s_dbl;
    take && opCode inside {3'h3, 3'h4, 3'h5};
  endsequence
  // low word alone, then high word alone
  sequence s_pair;
    resLoWe && !resHiWe ##1 resHiWe && !resLoWe;
  endsequence
  property p_dbl_words;
    s_dbl |-> ##7 s_pair;
  endproperty
  a_dbl_words: assert property (p_dbl_words) else $error("double words mistimed");
  property p_dbl_busy;
    s_dbl |=> !opReady [*7] ##1 opReady;
  endproperty
  a_dbl_busy: assert property (p_dbl_busy) else $error("double busy span wrong");
  property p_sgl;
    take && opCode == 3'h2 |=> resLoWe && !resHiWe && arithStatus[1] == resLo[31];
  endproperty
  a_sgl: assert property (p_sgl) else $error("single result or sign flag wrong");
  property p_neg_dbl;
    resHiWe |-> arithStatus[1] == resHi[31];
  endproperty
  a_neg_dbl: assert property (p_neg_dbl) else $error("negative flag off sign");
  // clear touches only the chosen accumulator
  property p_clr_fg;
    take && opCode == 3'h1 && !opAccumBg |=> fgAccum == '0 && $stable(bgAccum)
      && arithStatus[3:1] == 3'h0;
  endproperty
  a_clr_fg: assert property (p_clr_fg) else $error("foreground clear wrong");
  property p_clr_bg;
    take && opCode == 3'h1 && opAccumBg |=> bgAccum == '0 && $stable(fgAccum);
  endproperty
  a_clr_bg: assert property (p_clr_bg) else $error("background clear wrong");
  // bus idle, so no software clear can be under way
  property p_sticky_hold;
    s_axi_awready |-> (stickyStatus & $past(stickyStatus)) == $past(stickyStatus);
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky dropped");
  // a multiply has just written its flags: every set underflow, overflow or invalid flag is sticky by now
  property p_sticky_set;
    resHiWe || (resLoWe && opReady) |->
      ({arithStatus[0], arithStatus[3:2]} & ~stickyStatus[3:1]) == 3'h0 && !stickyStatus[0];
  endproperty
  a_sticky_set: assert property (p_sticky_set) else $error("sticky misses flag");
endmodule // fpm_mul_monitor

bind fpm_multiplier fpm_mul_monitor #(.ACC_W(ACC_W)) u_mon (.clk, .rst, .opValid, .opReady,
  .opCode, .opAccumBg, .resLoWe, .resHiWe, .resLo, .resHi, .fgAccum, .bgAccum, .arithStatus,
  .stickyStatus, .s_axi_awready);
`default_nettype wire

/* File: verification/fpm_seq_model.sv */
// sequencer and register file model facing the multiplier
`default_nettype none
module fpm_seq_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench request and result
  input wire logic go,
  input wire logic [2:0] code,
  input wire logic [63:0] a,
  input wire logic [63:0] b,
  output logic done,
  output logic [63:0] res,
  // operation port
  output logic opValid,
  output logic [2:0] opCode,
  output logic [63:0] opA,
  output logic [63:0] opB,
  input wire logic opReady,
  input wire logic resLoWe,
  input wire logic resHiWe,
  input wire logic [31:0] resLo,
  input wire logic [31:0] resHi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dbl;
  // idle operands show the inverse so stale data is never taken for fresh
  assign opA = opValid ? a : ~a;
  assign opB = opValid ? b : ~b;
  assign opCode = opValid ? code : 3'h0;
  ////////////////////////////////////////////////////////////////////////////////
  // hold request until taken, collect the written words
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      opValid <= 1'b0;
      done <= 1'b0;
      dbl <= 1'b0;
      res <= 64'h0;
    end else begin
      done <= (opValid && opReady && opCode == 3'h1) || (resLoWe && !dbl) || resHiWe;
      if (go) begin
        opValid <= 1'b1;
        dbl <= code > 3'h2;
      end else if (opReady) begin
        opValid <= 1'b0;
      end
      // program keeps nothing live in the scratch accumulator
      if (resLoWe) res[31:0] <= resLo;
      if (resHiWe) res[63:32] <= resHi;
    end
  end
endmodule // fpm_seq_model
`default_nettype wire

/* File: verification/fpm_multiplier_bench.sv */
// self-checking bench for the float multiplier and accumulator clear
`include "fpm_consts.vh"
`default_nettype none
module fpm_multiplier_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, go, bg, opValid, opReady, resLoWe, resHiWe, done;
  logic [2:0] code, opCode;
  logic [63:0] a, b, opA, opB, res;
  logic [31:0] resLo, resHi, s_axi_wdata, s_axi_rdata, rd;
  logic [79:0] fgAccum, bgAccum, keep;
  logic [3:0] arithStatus, stickyStatus, s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int errorCnt = 0;
  int compares = 0;
  fpm_multiplier DUT (.clk, .rst, .opValid, .opReady, .opCode, .opAccumBg(bg), .opA, .opB,
    .resLoWe, .resHiWe, .resLo, .resHi, .fgAccum, .bgAccum, .arithStatus, .stickyStatus,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready(1'b1));
  fpm_seq_model model (.clk, .rst, .go, .code, .a, .b, .done, .res, .opValid, .opCode, .opA,
    .opB, .opReady, .resLoWe, .resHiWe, .resLo, .resHi);
  // 40 MHz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
    compares++;
    if (g !== e) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bus masters; bready and rready stay high so every answer is taken at once
  task automatic axi_wr(input logic [3:0] ad, input logic [31:0] d);
    int n;
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    resp = s_axi_bresp;
    if (n >= 50) begin
      errorCnt++;
      print_verdict();
    end
  endtask
  task automatic axi_rd(input logic [3:0] ad, output logic [31:0] d);
    int n;
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    if (n >= 50) begin
      errorCnt++;
      print_verdict();
    end
  endtask
  // one operation through the sequencer model, waiting for its result
  task automatic run_op(input logic [2:0] c, input logic [63:0] x, input logic [63:0] y);
    int n;
    code <= c;
    a <= x;
    b <= y;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!done && n < 50);
    if (n >= 50) begin
      errorCnt++;
      print_verdict();
    end
  endtask
  task automatic sgl(input logic [63:0] x, input logic [63:0] y, input logic [31:0] e,
      input logic [3:0] f);
    run_op(`FPM_OP_SS, x, y);
    chk("single result", e, res[31:0]);
    chk("single flags", f, arithStatus);
  endtask
  task automatic dbl(input logic [2:0] c, input logic [63:0] x, input logic [63:0] y,
      input logic [63:0] e, input logic [3:0] f);
    run_op(c, x, y);
    chk("double result", e, res);
    chk("double flags", f, arithStatus);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    axi_rd(`FPM_REG_MODE, rd);
    chk("mode", 32'h0, rd);
    chk("rresp", 2'h0, resp);
    axi_wr(`FPM_REG_ARITH, 32'hf);
    chk("bresp", 2'h0, resp);
    axi_rd(`FPM_REG_ARITH, rd);
    chk("arith", 32'h0, rd);
    axi_rd(`FPM_REG_STICKY, rd);
    chk("sticky", 32'h0, rd);
    axi_rd(`FPM_REG_BUSY, rd);
    chk("busy idle", 32'h0, rd);
    $display("t_regs done");
  endtask
  task automatic t_single();
    sgl(64'h40000000, 64'h40400000, 32'h40c00000, 4'h0);
    sgl(64'hc0000000, 64'h40400000, 32'hc0c00000, 4'h2);
    sgl(64'h7f000000, 64'h7f000000, 32'h7f800000, 4'h8);
    sgl(64'h00800000, 64'h00800000, 32'h00000000, 4'h1);
    sgl(64'h7f800000, 64'h0, 32'h7fc00000, 4'h4);
    sgl(64'h7fc00000, 64'h40000000, 32'h7fc00000, 4'h4);
    chk("sticky set", 4'he, stickyStatus);
    sgl(64'h40000000, 64'h40400000, 32'h40c00000, 4'h0);
    chk("sticky held", 4'he, stickyStatus);
    axi_wr(`FPM_REG_STICKY, 32'hf);
    axi_rd(`FPM_REG_STICKY, rd);
    chk("sticky cleared", 32'h0, rd);
    $display("t_single done");
  endtask
  task automatic t_double();
    bg <= 1'b1;
    run_op(`FPM_OP_CLR, 64'h0, 64'h0);
    dbl(`FPM_OP_DD, 64'h4000000000000000, 64'h4008000000000000,
      64'h4018000000000000, 4'h0);
    chk("bg untouched", 80'h0, bgAccum);
    axi_wr(`FPM_REG_MODE, 32'h1);
    axi_rd(`FPM_REG_MODE, rd);
    chk("mode set", 32'h1, rd);
    bg <= 1'b0;
    run_op(`FPM_OP_CLR, 64'h0, 64'h0);
    dbl(`FPM_OP_DS, 64'h4000000000000000, 64'h40400000,
      64'h4018000000000000, 4'h0);
    chk("fg untouched", 80'h0, fgAccum);
    dbl(`FPM_OP_SSD, 64'h40000000, 64'h40400000, 64'h4018000000000000, 4'h0);
    // a nonzero low word proves the sixth-cycle write lands
    dbl(`FPM_OP_DD, 64'h3ff0000000000001, 64'h4000000000000000,
      64'h4000000000000001, 4'h0);
    dbl(`FPM_OP_DD, 64'h7fe0000000000000, 64'h7fe0000000000000,
      64'h7ff0000000000000, 4'h8);
    dbl(`FPM_OP_DD, 64'h0010000000000000, 64'h0010000000000000,
      64'h0, 4'h1);
    dbl(`FPM_OP_DD, 64'h7ff8000000000000, 64'hc000000000000000,
      64'h7ff8000000000000, 4'h4);
    dbl(`FPM_OP_DD, 64'hfff8000000000000, 64'h7ff8000000000000,
      64'hfff8000000000000, 4'h6);
    chk("sticky set", 4'he, stickyStatus);
    $display("t_double done");
  endtask
  task automatic t_clear();
    // park scratch data in the foreground accumulator so its clear is visible
    axi_wr(`FPM_REG_MODE, 32'h0);
    run_op(`FPM_OP_DD, 64'hc000000000000000, 64'h4008000000000000);
    chk("negative", 4'h2, arithStatus);
    keep = bgAccum;
    run_op(`FPM_OP_CLR, 64'h0, 64'h0);
    chk("fg cleared", 80'h0, fgAccum);
    chk("bg kept", keep, bgAccum);
    chk("flags cleared", 4'h0, arithStatus);
    chk("sticky kept", 4'he, stickyStatus);
    $display("t_clear done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset for ten cycles, then the scenarios in turn
  initial begin
    rst = 1'b1;
    go = 1'b0;
    bg = 1'b0;
    code = 3'h0;
    a = 64'h0;
    b = 64'h0;
    s_axi_awaddr = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_araddr = 4'h0;
    s_axi_arvalid = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_single();
    t_double();
    t_clear();
    print_verdict();
  end
endmodule // fpm_multiplier_bench
`default_nettype wire
